// File: logic/amp_cmp_pkg.sv
package amp_cmp_pkg;
  // ****************************************
  // register map (byte offsets)
  // ****************************************
  localparam logic [7:0] OFS_RESULT_TRIM = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_AMP2 = 8'h08;
  localparam logic [7:0] OFS_EDGE = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_RESULT = 7;
  localparam int BIT_CAL_MODE = 6;
  localparam int BIT_CAL_REF = 5;
  localparam int BIT_NONINV_SRC = 7;
  localparam int BIT_IRQ_EN = 3;
  localparam int BIT_PIN_OUT_EN = 2;
  localparam int BIT_INV_SRC = 1;
  localparam int BIT_CMP_EN = 0;
  localparam int BIT_A2_POS_SEL = 0;
  localparam int BIT_A2_NEG_SEL = 1;
  localparam int BIT_A2_REF_LO = 2;
  localparam int BIT_A2_A1_POS = 4;
  localparam int BIT_A2_A1_NEG = 5;
  localparam int BIT_A2_GAIN = 6;
  localparam int BIT_A2_BUF = 7;
  localparam int BIT_A2_EN = 8;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [4:0] TRIM_RST = 5'h10;
  localparam logic NONINV_SRC_RST = 1'b1;
  localparam logic INV_SRC_RST = 1'b1;
  // ****************************************
  // edge select and reference select encodings
  // ****************************************
  typedef enum logic [1:0] {
    EDGE_OFF = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } edge_sel_t;
  localparam logic [1:0] REF_NONE = 2'b00;
  localparam logic [1:0] REF_HIGH = 2'b01;
  localparam logic [1:0] REF_MID = 2'b10;
  localparam logic [1:0] REF_LOW = 2'b11;
endpackage : amp_cmp_pkg

// File: logic/amp_comparator_switch_ctrl.sv
`timescale 1ns/1ps
module amp_comparator_switch_ctrl #(
  parameter bit HAS_CAL = 1'b1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic cmpOneRaw,
  output logic cmpOneEnableOut,
  output logic cmpOneCalModeOut,
  output logic cmpOneCalRefOut,
  output logic [4:0] cmpOneTrimOut,
  output logic cmpOneNonInvFromPin,
  output logic cmpOneInvFromPin,
  output logic cmpOnePinOutEn,
  output logic cmpOnePinOutVal,
  output logic cmpOneNonInvPinOwned,
  output logic cmpOneInvPinOwned,
  output logic cmpOneIrqPulse,
  output logic posPinSwitch,
  output logic negPinSwitch,
  output logic gainSwitches,
  output logic amp1NegRouteSwitch,
  output logic bufferFeedbackSwitch,
  output logic amp1PosRouteSwitch,
  output logic highRefSwitch,
  output logic midRefSwitch,
  output logic lowRefSwitch,
  output logic amp2NegPinOwned,
  output logic amp2PosPinOwned,
  output logic amp2OutPinOwned
);
  // ****************************************
  // registers
  // ****************************************
  logic calMode_r;
  logic calRef_r;
  logic [4:0] trim_r;
  logic nonInvSrc_r;
  logic irqEn_r;
  logic pinOutEn_r;
  logic invSrc_r;
  logic cmpEn_r;
  logic [8:0] amp2Ctl_r;
  logic [1:0] edgeSel_r;
  logic syncA_r;
  logic syncB_r;
  logic result_r;
  logic wrPend_r;
  logic [7:0] wrAddr_r;
  logic rdPend_r;
  logic [7:0] rdAddr_r;
  logic calActive;
  logic nonInvEff;
  logic invEff;
  logic [31:0] rdData;
  logic addrPhase;
  logic wrResultTrim;
  logic wrControl;
  logic wrAmp2;
  logic wrEdge;

  assign calActive = HAS_CAL & calMode_r;
  assign nonInvEff = nonInvSrc_r | calActive;
  assign invEff = invSrc_r | calActive;
  assign addrPhase = hsel & htrans[1] & hready;

  // ****************************************
  // bus slave
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPend_r <= 1'b0;
      rdPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
      rdAddr_r <= 8'h00;
    end else begin
      wrPend_r <= addrPhase & hwrite;
      rdPend_r <= addrPhase & ~hwrite;
      if (addrPhase) begin
        wrAddr_r <= haddr[7:0];
        rdAddr_r <= haddr[7:0];
      end
    end
  end

  // ****************************************
  // register write decode
  // ****************************************
  always_comb begin
    wrResultTrim = 1'b0;
    wrControl = 1'b0;
    wrAmp2 = 1'b0;
    wrEdge = 1'b0;
    if (wrPend_r) begin
      if (wrAddr_r == amp_cmp_pkg::OFS_RESULT_TRIM) begin
        wrResultTrim = 1'b1;
      end else if (wrAddr_r == amp_cmp_pkg::OFS_CONTROL) begin
        wrControl = 1'b1;
      end else if (wrAddr_r == amp_cmp_pkg::OFS_AMP2) begin
        wrAmp2 = 1'b1;
      end else if (wrAddr_r == amp_cmp_pkg::OFS_EDGE) begin
        wrEdge = 1'b1;
      end
    end
  end

  // reduced variant keeps no calibration state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      calMode_r <= 1'b0;
      calRef_r <= 1'b0;
      trim_r <= amp_cmp_pkg::TRIM_RST;
    end else if (wrResultTrim && HAS_CAL) begin
      calMode_r <= hwdata[amp_cmp_pkg::BIT_CAL_MODE];
      calRef_r <= hwdata[amp_cmp_pkg::BIT_CAL_REF];
      trim_r <= hwdata[4:0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nonInvSrc_r <= amp_cmp_pkg::NONINV_SRC_RST;
      irqEn_r <= 1'b0;
      pinOutEn_r <= 1'b0;
      invSrc_r <= amp_cmp_pkg::INV_SRC_RST;
      cmpEn_r <= 1'b0;
    end else if (wrControl) begin
      // stored even while calibration forces the effective value
      nonInvSrc_r <= hwdata[amp_cmp_pkg::BIT_NONINV_SRC];
      irqEn_r <= hwdata[amp_cmp_pkg::BIT_IRQ_EN];
      pinOutEn_r <= hwdata[amp_cmp_pkg::BIT_PIN_OUT_EN];
      invSrc_r <= hwdata[amp_cmp_pkg::BIT_INV_SRC];
      cmpEn_r <= hwdata[amp_cmp_pkg::BIT_CMP_EN];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      amp2Ctl_r <= 9'h000;
    end else if (wrAmp2) begin
      amp2Ctl_r <= hwdata[8:0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      edgeSel_r <= amp_cmp_pkg::EDGE_OFF;
    end else if (wrEdge) begin
      edgeSel_r <= hwdata[1:0];
    end
  end

  // ****************************************
  // register read mux
  // ****************************************
  always_comb begin
    rdData = 32'h0000_0000;
    if (rdAddr_r == amp_cmp_pkg::OFS_RESULT_TRIM) begin
      rdData[amp_cmp_pkg::BIT_RESULT] = result_r;
      if (HAS_CAL) begin
        rdData[amp_cmp_pkg::BIT_CAL_MODE] = calMode_r;
        rdData[amp_cmp_pkg::BIT_CAL_REF] = calRef_r;
        rdData[4:0] = trim_r;
      end
    end else if (rdAddr_r == amp_cmp_pkg::OFS_CONTROL) begin
      rdData[amp_cmp_pkg::BIT_NONINV_SRC] = nonInvEff;
      rdData[amp_cmp_pkg::BIT_IRQ_EN] = irqEn_r;
      rdData[amp_cmp_pkg::BIT_PIN_OUT_EN] = pinOutEn_r;
      rdData[amp_cmp_pkg::BIT_INV_SRC] = invEff;
      rdData[amp_cmp_pkg::BIT_CMP_EN] = cmpEn_r;
    end else if (rdAddr_r == amp_cmp_pkg::OFS_AMP2) begin
      rdData[8:0] = amp2Ctl_r;
    end else if (rdAddr_r == amp_cmp_pkg::OFS_EDGE) begin
      rdData[1:0] = edgeSel_r;
    end else if (rdAddr_r == amp_cmp_pkg::OFS_STATUS) begin
      rdData[0] = result_r;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addrPhase & ~hwrite) begin
      hrdata <= 32'h0000_0000;
    end else if (rdPend_r) begin
      hrdata <= rdData;
    end
  end

  // read data is registered one cycle after the data phase opens
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hreadyout <= 1'b1;
    end else if (addrPhase & ~hwrite) begin
      hreadyout <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // ****************************************
  // comparator result path
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      syncA_r <= 1'b0;
      syncB_r <= 1'b0;
      result_r <= 1'b0;
    end else begin
      syncA_r <= cmpOneRaw;
      syncB_r <= syncA_r;
      result_r <= cmpEn_r & syncB_r;
    end
  end

  // ****************************************
  // interrupt edge detection
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmpOneIrqPulse <= 1'b0;
    end else begin
      case (edgeSel_r)
        amp_cmp_pkg::EDGE_RISE: cmpOneIrqPulse <= irqEn_r & cmpEn_r & ~result_r & syncB_r;
        amp_cmp_pkg::EDGE_FALL: cmpOneIrqPulse <= irqEn_r & cmpEn_r & result_r & ~syncB_r;
        amp_cmp_pkg::EDGE_BOTH: cmpOneIrqPulse <= irqEn_r & cmpEn_r & (result_r ^ syncB_r);
        default: cmpOneIrqPulse <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmpOneEnableOut <= 1'b0;
      cmpOneCalModeOut <= 1'b0;
      cmpOneCalRefOut <= 1'b0;
      cmpOneTrimOut <= amp_cmp_pkg::TRIM_RST;
    end else begin
      cmpOneEnableOut <= cmpEn_r;
      cmpOneCalModeOut <= calActive;
      cmpOneCalRefOut <= calRef_r;
      cmpOneTrimOut <= trim_r;
    end
  end

  // effective input routing, forced to the pins during calibration
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmpOneNonInvFromPin <= amp_cmp_pkg::NONINV_SRC_RST;
      cmpOneInvFromPin <= amp_cmp_pkg::INV_SRC_RST;
    end else begin
      cmpOneNonInvFromPin <= nonInvEff;
      cmpOneInvFromPin <= invEff;
    end
  end

  // ****************************************
  // comparator pin ownership
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmpOnePinOutEn <= 1'b0;
      cmpOnePinOutVal <= 1'b0;
      cmpOneNonInvPinOwned <= 1'b0;
      cmpOneInvPinOwned <= 1'b0;
    end else begin
      cmpOnePinOutEn <= cmpEn_r & pinOutEn_r;
      cmpOnePinOutVal <= result_r;
      cmpOneNonInvPinOwned <= cmpEn_r & nonInvEff;
      cmpOneInvPinOwned <= cmpEn_r & invEff;
    end
  end

  // ****************************************
  // amplifier-2 switch and pin decode
  // ****************************************
  logic a2Pos;
  logic a2Neg;
  logic [1:0] a2Ref;
  logic a2Gain;
  logic a2Buf;
  logic amp2_enable;
  logic a2FromAmp1Pos;
  logic a2FromAmp1Neg;
  logic refAllowed;
  assign a2Pos = amp2Ctl_r[amp_cmp_pkg::BIT_A2_POS_SEL];
  assign a2Neg = amp2Ctl_r[amp_cmp_pkg::BIT_A2_NEG_SEL];
  assign a2Ref = amp2Ctl_r[amp_cmp_pkg::BIT_A2_REF_LO +: 2];
  assign a2Gain = amp2Ctl_r[amp_cmp_pkg::BIT_A2_GAIN];
  assign a2Buf = amp2Ctl_r[amp_cmp_pkg::BIT_A2_BUF];
  assign amp2_enable = amp2Ctl_r[amp_cmp_pkg::BIT_A2_EN];
  assign a2FromAmp1Pos = amp2Ctl_r[amp_cmp_pkg::BIT_A2_A1_POS];
  assign a2FromAmp1Neg = amp2Ctl_r[amp_cmp_pkg::BIT_A2_A1_NEG];
  // positive pin and amp1 route take priority over references
  assign refAllowed = ~a2Pos & ~a2FromAmp1Pos;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      posPinSwitch <= 1'b0;
      negPinSwitch <= 1'b0;
      gainSwitches <= 1'b0;
      amp1NegRouteSwitch <= 1'b0;
      bufferFeedbackSwitch <= 1'b0;
      amp1PosRouteSwitch <= 1'b0;
      highRefSwitch <= 1'b0;
      midRefSwitch <= 1'b0;
      lowRefSwitch <= 1'b0;
    end else begin
      posPinSwitch <= a2Pos;
      negPinSwitch <= a2Neg;
      gainSwitches <= amp2_enable & a2Gain;
      amp1NegRouteSwitch <= ~a2Neg & a2FromAmp1Neg;
      // feedback stays open when a reference drives the input
      bufferFeedbackSwitch <= amp2_enable & a2Buf & a2Pos;
      amp1PosRouteSwitch <= ~a2Pos & a2FromAmp1Pos;
      highRefSwitch <= refAllowed & (a2Ref == amp_cmp_pkg::REF_HIGH);
      midRefSwitch <= refAllowed & (a2Ref == amp_cmp_pkg::REF_MID);
      lowRefSwitch <= refAllowed & (a2Ref == amp_cmp_pkg::REF_LOW);
    end
  end

  // ****************************************
  // amplifier-2 pin ownership
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      amp2NegPinOwned <= 1'b0;
      amp2PosPinOwned <= 1'b0;
      amp2OutPinOwned <= 1'b0;
    end else begin
      amp2OutPinOwned <= amp2_enable;
      amp2PosPinOwned <= amp2_enable & a2Pos;
      amp2NegPinOwned <= amp2_enable & (a2Neg | a2Gain);
    end
  end
endmodule : amp_comparator_switch_ctrl

// File: testbench/amp_cmp_monitor.sv
`timescale 1ns/1ps
module amp_cmp_monitor (
  input wire logic clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic cmpOneEnableOut,
  input wire logic cmpOneCalModeOut,
  input wire logic cmpOneNonInvFromPin,
  input wire logic cmpOneInvFromPin,
  input wire logic cmpOnePinOutEn,
  input wire logic cmpOneNonInvPinOwned,
  input wire logic cmpOneInvPinOwned,
  input wire logic cmpOneIrqPulse,
  input wire logic posPinSwitch,
  input wire logic gainSwitches,
  input wire logic bufferFeedbackSwitch,
  input wire logic highRefSwitch,
  input wire logic midRefSwitch,
  input wire logic lowRefSwitch,
  input wire logic amp2NegPinOwned,
  input wire logic amp2PosPinOwned,
  input wire logic amp2OutPinOwned
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_read_wait_state: assert property (
    hsel && htrans[1] && !hwrite && hready |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not one wait state");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  chk_ref_onehot: assert property (
    $onehot0({highRefSwitch, midRefSwitch, lowRefSwitch}))
    else $error("more than one reference switch closed");
  chk_pos_over_ref: assert property (
    posPinSwitch |-> !(highRefSwitch || midRefSwitch || lowRefSwitch))
    else $error("reference switch closed with positive pin switch");
  chk_amp_off_open: assert property (
    !amp2OutPinOwned |-> !gainSwitches && !bufferFeedbackSwitch && !amp2PosPinOwned
      && !amp2NegPinOwned)
    else $error("amplifier disabled but pins or gain switches held");
  chk_cal_forces_sel: assert property (
    cmpOneCalModeOut |-> cmpOneNonInvFromPin && cmpOneInvFromPin)
    else $error("source selects not forced in calibration");
  chk_cmp_off_release: assert property (
    !cmpOneEnableOut |-> !(cmpOnePinOutEn || cmpOneNonInvPinOwned || cmpOneInvPinOwned))
    else $error("disabled comparator holds pins");
  chk_irq_single: assert property (cmpOneIrqPulse |=> !cmpOneIrqPulse)
    else $error("interrupt pulse longer than one cycle");
  chk_irq_needs_en: assert property (cmpOneIrqPulse |-> cmpOneEnableOut)
    else $error("interrupt from disabled comparator");
endmodule : amp_cmp_monitor

bind amp_comparator_switch_ctrl amp_cmp_monitor amp_cmp_monitor_inst (.clk, .resetn, .hsel,
  .htrans, .hwrite, .hready, .hreadyout, .hresp, .cmpOneEnableOut, .cmpOneCalModeOut,
  .cmpOneNonInvFromPin, .cmpOneInvFromPin, .cmpOnePinOutEn, .cmpOneNonInvPinOwned,
  .cmpOneInvPinOwned, .cmpOneIrqPulse, .posPinSwitch, .gainSwitches, .bufferFeedbackSwitch,
  .highRefSwitch, .midRefSwitch, .lowRefSwitch, .amp2NegPinOwned, .amp2PosPinOwned,
  .amp2OutPinOwned);

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk, resetn, hsel, hwrite, cmpOneRaw;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic hreadyout, hresp, pinEn, nOwn, iOwn, irq, pinVal;
  logic [4:0] trim;
  wire [8:0] sw;
  wire [2:0] own;
  wire [4:0] ctl;
  int err_total, n_checks, cyc, pulses;
  logic [20:0] tbl [11] = '{{9'h103, 9'b110000000, 3'b111}, {9'h106, 9'b010000100, 3'b101},
    {9'h10A, 9'b010000010, 3'b101}, {9'h10E, 9'b010000001, 3'b101},
    {9'h112, 9'b010001000, 3'b101}, {9'h121, 9'b100100000, 3'b011},
    {9'h143, 9'b111000000, 3'b111}, {9'h141, 9'b101000000, 3'b111},
    {9'h181, 9'b100010000, 3'b011}, {9'h184, 9'b000000100, 3'b001},
    {9'h043, 9'b110000000, 3'b000}};
  amp_comparator_switch_ctrl amp_comparator_switch_ctrl_inst (.clk(clk), .resetn(resetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .cmpOneRaw(cmpOneRaw), .cmpOneEnableOut(ctl[4]), .cmpOneCalModeOut(ctl[3]),
    .cmpOneCalRefOut(ctl[2]), .cmpOneTrimOut(trim), .cmpOneNonInvFromPin(ctl[1]),
    .cmpOneInvFromPin(ctl[0]),
    .cmpOnePinOutEn(pinEn), .cmpOnePinOutVal(pinVal), .cmpOneNonInvPinOwned(nOwn),
    .cmpOneInvPinOwned(iOwn), .cmpOneIrqPulse(irq), .posPinSwitch(sw[8]),
    .negPinSwitch(sw[7]), .gainSwitches(sw[6]), .amp1NegRouteSwitch(sw[5]),
    .bufferFeedbackSwitch(sw[4]), .amp1PosRouteSwitch(sw[3]), .highRefSwitch(sw[2]),
    .midRefSwitch(sw[1]), .lowRefSwitch(sw[0]), .amp2NegPinOwned(own[2]),
    .amp2PosPinOwned(own[1]), .amp2OutPinOwned(own[0]));
  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(nm, rd, exp);
    check("resp", {31'h0, hresp}, 32'h0);
  endtask : rdchk
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  // ****************************************
  // clock, pulse counter, timeout
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (irq === 1'b1) pulses++;
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    {resetn, hsel, hwrite, cmpOneRaw, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    check("trim out", {27'h0, trim}, 32'h10);
    check("ctl reset", {27'h0, ctl}, 32'h03);
    rdchk("reg0 reset", amp_cmp_pkg::OFS_RESULT_TRIM, 32'h10);
    rdchk("reg1 reset", amp_cmp_pkg::OFS_CONTROL, 32'h82);
    rdchk("amp2 reset", amp_cmp_pkg::OFS_AMP2, 32'h0);
    rdchk("edge reset", amp_cmp_pkg::OFS_EDGE, 32'h0);
    rdchk("unmapped", 8'h20, 32'h0);
    xfer(1'b1, amp_cmp_pkg::OFS_RESULT_TRIM, 32'hFF);
    xfer(1'b1, amp_cmp_pkg::OFS_CONTROL, 32'h70);
    rdchk("reg0 cal", amp_cmp_pkg::OFS_RESULT_TRIM, 32'h7F);
    rdchk("reg1 forced", amp_cmp_pkg::OFS_CONTROL, 32'h82);
    check("ctl cal", {27'h0, ctl}, 32'h0F);
    xfer(1'b1, amp_cmp_pkg::OFS_RESULT_TRIM, 32'h0A);
    rdchk("reg1 restored", amp_cmp_pkg::OFS_CONTROL, 32'h0);
    check("trim out", {27'h0, trim}, 32'h0A);
    check("ctl normal", {27'h0, ctl}, 32'h00);
    xfer(1'b1, amp_cmp_pkg::OFS_CONTROL, 32'h8F);
    repeat (2) @(posedge clk);
    check("cmp pins", {29'h0, pinEn, nOwn, iOwn}, 32'h7);
    check("ctl enabled", {27'h0, ctl}, 32'h13);
    cmpOneRaw <= 1'b1;
    repeat (6) @(posedge clk);
    check("pin value", {31'h0, pinVal}, 32'h1);
    rdchk("reg0 result", amp_cmp_pkg::OFS_RESULT_TRIM, 32'h8A);
    rdchk("status", amp_cmp_pkg::OFS_STATUS, 32'h1);
    cmpOneRaw <= 1'b0;
    repeat (6) @(posedge clk);
    for (int e = 0; e < 5; e++) begin
      // last pass: both edges selected but interrupt disabled
      if (e == 4) xfer(1'b1, amp_cmp_pkg::OFS_CONTROL, 32'h87);
      xfer(1'b1, amp_cmp_pkg::OFS_EDGE, (e == 4) ? 32'h3 : e);
      pulses = 0;
      cmpOneRaw <= 1'b1;
      repeat (6) @(posedge clk);
      check("rise irq", pulses, {31'h0, e < 4 && e[0]});
      pulses = 0;
      cmpOneRaw <= 1'b0;
      repeat (6) @(posedge clk);
      check("fall irq", pulses, {31'h0, e < 4 && e[1]});
    end
    xfer(1'b1, amp_cmp_pkg::OFS_CONTROL, 32'h0);
    repeat (2) @(posedge clk);
    check("cmp pins off", {29'h0, pinEn, nOwn, iOwn}, 32'h0);
    check("ctl off", {27'h0, ctl}, 32'h00);
    foreach (tbl[i]) begin
      xfer(1'b1, amp_cmp_pkg::OFS_AMP2, {23'h0, tbl[i][20:12]});
      repeat (2) @(posedge clk);
      check("switches", {23'h0, sw}, {23'h0, tbl[i][11:3]});
      check("pin owner", {29'h0, own}, {29'h0, tbl[i][2:0]});
    end
    complete_run();
  end
endmodule : tb_top
